// ### core/ptrp_pkg.sv
package ptrp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // transfer instruction fields
    localparam logic [5:0] XFER_OPCODE = 6'h38;
    localparam logic [5:0] DEV_READER = 6'h01;
    localparam logic [5:0] DEV_PUNCH = 6'h02;
    localparam int BIT_SKIP = 0;
    localparam int BIT_CLEAR = 1;
    localparam int BIT_SELECT = 2;
    localparam int BIT_RDCLR = 3;
    localparam int BIT_BINARY = 5;

    ////////////////////////////////////////////////////////////////////////////
    // tape frame layout
    localparam int WORD_W = 18;
    localparam int FRAME_W = 8;
    localparam int CH7 = 6;
    localparam int CH8 = 7;
    localparam logic [1:0] LAST_FRAME_IDX = 2'h2;
    localparam logic [1:0] BIN_CH87 = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [17:0] RDR_BUF_RESET = 18'h00000;
    localparam logic [7:0] PUN_BUF_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic valid;
        logic [17:0] code;
    } ptrp_xfer_t;

    typedef struct packed {
        logic [7:0] frame;
        logic strobe;
        logic no_tape;
        logic pun_done;
        logic pun_low;
        logic pun_feed;
        logic readin_key;
    } ptrp_pins_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_RUN = 2'b01,
        RD_WAIT = 2'b10
    } ptrp_rd_state_t;

    typedef enum logic {
        PU_IDLE = 1'b0,
        PU_BUSY = 1'b1
    } ptrp_pu_state_t;

endpackage

// ### core/ptrp_fifo.sv
`timescale 1ns/1ps

// depth must be a power of two; pointers wrap freely
module ptrp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;

    wire push = in_valid && in_ready;
    wire load = (cnt != '0) && (!out_valid || out_ready);

    assign in_ready = (cnt != (AW+1)'(DEPTH));

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || flush)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else
        begin
            if (push)
            begin
                wp <= wp + 1'b1;
            end
            if (load)
            begin
                out_data <= mem[rp];
                rp <= rp + 1'b1;
                out_valid <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid <= 1'b0;
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(load);
        end
    end

endmodule // ptrp_fifo

// ### core/ptrp_ctrl.sv
`timescale 1ns/1ps

// Operation
// [R1] readin key latches readin, forces binary mode
// [R2] readin: three frames, word, then interrupt
// [R3] sequencer stores words at consecutive addresses
// [R4] channel 7 in readin raises skip request
// [R5] sequencer executes final word, not stored
// [R6] char select: one frame, buffer, set flag
// [R7] reader flag drives interrupt request
// [R8] reader skip test answers reader flag
// [R9] read puts character in low bits
// [R10] read-and-clear also clears reader flag
// [R11] binary select: clear flag, assemble 18 bits
// [R12] binary counts channel-8 frames up to three
// [R13] punch select captures low eight bits
// [R14] low tape switch stops the punch
// [R15] punch runs on select or feed
// [R16] char mode punches eight-bit character
// [R17] binary: six bits, ch8 on, ch7 off
// [R18] punch skip test answers punch flag
// [R19] punch clear clears flag and buffer
// [R20] char select punches, flag on completion
// [R21] binary select punches, flag on completion
// [R22] status: punch flag bit 02, no-tape 09
// [R23] status: reader flag on bit 01
// [R24] status: reader no-tape on bit 08
// [R25] clear-flag read merges buffer by OR
// [R26] no tape sets reader flag on select
// [R27] reset clears flags, buffers, readin
module ptrp_ctrl #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire ptrp_pkg::ptrp_xfer_t xfer,
    input wire logic io_status_read,
    input wire logic [17:0] io_ac,
    output logic io_skip,
    output logic [17:0] io_data,
    output logic io_data_valid,
    output logic io_data_or,
    output logic reader_irq,
    output logic punch_irq,
    input wire logic readin_take,
    output logic readin_irq,
    output logic readin_skip,
    output logic readin_active,
    input wire ptrp_pkg::ptrp_pins_t pins,
    output logic rdr_advance,
    output logic [7:0] pun_frame,
    output logic pun_strobe,
    output logic pun_motor
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a rise counts once stages two and three agree high; a fall counts as soon as they differ; while both are low the filter holds its value
    ptrp_pkg::ptrp_pins_t s1;
    ptrp_pkg::ptrp_pins_t s2;
    ptrp_pkg::ptrp_pins_t s3;
    ptrp_pkg::ptrp_pins_t filt;
    ptrp_pkg::ptrp_pins_t filt_d;

    wire ptrp_pkg::ptrp_pins_t next_filt = (s2 & s3) | (filt & ~(s2 ^ s3));

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
            filt_d <= '0;
        end
        else
        begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
            filt_d <= filt;
        end
    end

    wire strobe_rise = filt.strobe && !filt_d.strobe;
    wire done_rise = filt.pun_done && !filt_d.pun_done;
    wire key_rise = filt.readin_key && !filt_d.readin_key;

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode
    wire is_xfer = xfer.valid && (xfer.code[17:12] == ptrp_pkg::XFER_OPCODE);
    wire rdr_dev = is_xfer && (xfer.code[11:6] == ptrp_pkg::DEV_READER);
    wire pun_dev = is_xfer && (xfer.code[11:6] == ptrp_pkg::DEV_PUNCH);
    wire rdr_skip_cmd = rdr_dev && xfer.code[ptrp_pkg::BIT_SKIP];
    wire rdr_rd = rdr_dev && xfer.code[ptrp_pkg::BIT_CLEAR];
    wire rdr_go = rdr_dev && xfer.code[ptrp_pkg::BIT_SELECT];
    wire rdr_bin = xfer.code[ptrp_pkg::BIT_BINARY];
    wire pun_skip_cmd = pun_dev && xfer.code[ptrp_pkg::BIT_SKIP];
    wire pun_clr = pun_dev && xfer.code[ptrp_pkg::BIT_CLEAR];
    wire pun_go = pun_dev && xfer.code[ptrp_pkg::BIT_SELECT];
    wire pun_bin = xfer.code[ptrp_pkg::BIT_BINARY];

    ////////////////////////////////////////////////////////////////////////////
    // reader state
    ptrp_pkg::ptrp_rd_state_t rd_state;
    logic rdr_flag;
    logic bin_mode;
    logic last;
    logic [1:0] frame_cnt;
    logic [17:0] rdr_buf;

    wire [7:0] fifo_frame;
    wire fifo_out_valid;
    wire fifo_in_ready;
    wire fifo_out_ready = (rd_state == ptrp_pkg::RD_RUN);
    wire rdr_idle = (rd_state == ptrp_pkg::RD_IDLE);
    wire prog_start = rdr_go && rdr_idle && !key_rise && !readin_active && !filt.no_tape;
    wire run_start = (key_rise && rdr_idle) || prog_start;
    wire pop = fifo_out_valid && fifo_out_ready;
    // leader and trailer carry only the feed hole; ignored in binary mode
    wire counted = pop && (!bin_mode || fifo_frame[ptrp_pkg::CH8]); // [R12]
    wire rdr_complete = counted && (!bin_mode || frame_cnt == ptrp_pkg::LAST_FRAME_IDX); // [R2] [R11] [R12]
    wire next_last = last || fifo_frame[ptrp_pkg::CH7];
    wire run_lost = (rd_state == ptrp_pkg::RD_RUN) && filt.no_tape && !readin_active;
    wire [17:0] next_buf = bin_mode ? {rdr_buf[11:0], fifo_frame[5:0]} : {10'h000, fifo_frame};
    wire tape_no_sel = rdr_go && filt.no_tape && !readin_active;

    // tape stops once the buffer fills, so no frame is dropped
    assign rdr_advance = (rd_state == ptrp_pkg::RD_RUN) && fifo_in_ready;

    ptrp_fifo #(
        .WIDTH(ptrp_pkg::FRAME_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .flush(prog_start),
        .in_data(filt.frame),
        .in_valid(rdr_advance && strobe_rise),
        .in_ready(fifo_in_ready),
        .out_data(fifo_frame),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rd_state <= ptrp_pkg::RD_IDLE; // [R27]
            readin_active <= 1'b0;
            bin_mode <= 1'b0;
            last <= 1'b0;
            frame_cnt <= 2'h0;
            rdr_buf <= ptrp_pkg::RDR_BUF_RESET;
        end
        else
        begin
            case (rd_state)
                ptrp_pkg::RD_IDLE:
                begin
                    if (key_rise)
                    begin
                        readin_active <= 1'b1; // [R1]
                        bin_mode <= 1'b1; // [R1]
                    end
                    else if (prog_start)
                    begin
                        bin_mode <= rdr_bin; // [R6] [R11]
                    end
                    if (run_start)
                    begin
                        rd_state <= ptrp_pkg::RD_RUN;
                        frame_cnt <= 2'h0;
                        last <= 1'b0;
                    end
                end
                ptrp_pkg::RD_RUN:
                begin
                    if (counted)
                    begin
                        rdr_buf <= next_buf; // [R6] [R11]
                        frame_cnt <= frame_cnt + 2'h1;
                        last <= next_last;
                    end
                    if (rdr_complete)
                    begin
                        frame_cnt <= 2'h0;
                        rd_state <= readin_active ? ptrp_pkg::RD_WAIT : ptrp_pkg::RD_IDLE;
                    end
                    else if (run_lost)
                    begin
                        rd_state <= ptrp_pkg::RD_IDLE;
                    end
                end
                ptrp_pkg::RD_WAIT:
                begin
                    // sequencer steps its address per take; the last word is not stored there
                    if (readin_take) // [R3] [R5]
                    begin
                        rd_state <= last ? ptrp_pkg::RD_IDLE : ptrp_pkg::RD_RUN;
                        readin_active <= !last;
                        last <= 1'b0;
                    end
                end
                default:
                begin
                    rd_state <= ptrp_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // set wins over clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdr_flag <= 1'b0;
            readin_irq <= 1'b0;
            readin_skip <= 1'b0;
        end
        else
        begin
            if (rdr_rd || prog_start)
            begin
                rdr_flag <= 1'b0; // [R10] [R11] [R25]
            end
            if ((rdr_complete && !readin_active) || tape_no_sel || run_lost)
            begin
                rdr_flag <= 1'b1; // [R6] [R26]
            end
            if (readin_take)
            begin
                readin_irq <= 1'b0;
                readin_skip <= 1'b0;
            end
            if (rdr_complete && readin_active)
            begin
                readin_irq <= 1'b1; // [R2]
                readin_skip <= next_last; // [R4]
            end
        end
    end

    assign reader_irq = rdr_flag; // [R7]

    ////////////////////////////////////////////////////////////////////////////
    // punch
    ptrp_pkg::ptrp_pu_state_t pu_state;
    logic pun_flag;

    // a low supply refuses the select and leaves the flag as it was, neither cleared nor set
    wire pun_go_ok = pun_go && !filt.pun_low; // [R14]
    wire [7:0] pun_load = pun_bin ? {ptrp_pkg::BIN_CH87, io_ac[5:0]} : io_ac[7:0]; // [R13] [R16] [R17]
    wire pun_finish = (pu_state == ptrp_pkg::PU_BUSY) && done_rise;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pu_state <= ptrp_pkg::PU_IDLE;
            pun_flag <= 1'b0; // [R27]
            pun_frame <= ptrp_pkg::PUN_BUF_RESET;
            pun_strobe <= 1'b0;
        end
        else
        begin
            pun_strobe <= 1'b0;
            if (pun_clr)
            begin
                pun_flag <= 1'b0; // [R19]
                pun_frame <= ptrp_pkg::PUN_BUF_RESET; // [R19]
            end
            if (pun_go_ok)
            begin
                pun_frame <= pun_load; // [R13]
                pun_flag <= 1'b0;
                pun_strobe <= 1'b1; // [R20] [R21]
                pu_state <= ptrp_pkg::PU_BUSY;
            end
            else if (pun_finish)
            begin
                pun_flag <= 1'b1; // [R20] [R21]
                pu_state <= ptrp_pkg::PU_IDLE;
            end
        end
    end

    assign pun_motor = ((pu_state == ptrp_pkg::PU_BUSY) || filt.pun_feed) && !filt.pun_low; // [R14] [R15]
    assign punch_irq = pun_flag;

    ////////////////////////////////////////////////////////////////////////////
    // bus answers
    wire [17:0] status_word = {1'b0, rdr_flag, pun_flag, 5'h00, filt.no_tape, filt.pun_low, 8'h00}; // [R22] [R23] [R24]

    assign io_skip = (rdr_skip_cmd && rdr_flag) || (pun_skip_cmd && pun_flag); // [R8] [R18]

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            io_data <= ptrp_pkg::RDR_BUF_RESET;
            io_data_valid <= 1'b0;
            io_data_or <= 1'b0;
        end
        else
        begin
            io_data_valid <= rdr_rd || io_status_read || (rdr_complete && readin_active);
            if (rdr_rd)
            begin
                io_data <= rdr_buf; // [R9]
                io_data_or <= !xfer.code[ptrp_pkg::BIT_RDCLR]; // [R25]
            end
            else if (io_status_read)
            begin
                io_data <= status_word;
                io_data_or <= 1'b0;
            end
            else if (rdr_complete && readin_active)
            begin
                io_data <= next_buf; // [R2]
                io_data_or <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_sel_start;
        prog_start ##1 (rd_state == ptrp_pkg::RD_RUN);
    endsequence

    sequence s_word_done;
        rdr_complete && !readin_active;
    endsequence

    a_sel_clears_flag: assert property (s_sel_start |-> !rdr_flag) // [R11]
        else $error("select did not clear reader flag");
    a_word_sets_flag: assert property (s_word_done |=> rdr_flag && reader_irq) // [R6]
        else $error("finished character did not set flag");
    a_skip_reader: assert property (rdr_skip_cmd && !pun_skip_cmd |-> io_skip == rdr_flag) // [R8]
        else $error("reader skip wrong");
    a_skip_punch: assert property (pun_skip_cmd && !rdr_skip_cmd |-> io_skip == pun_flag) // [R18]
        else $error("punch skip wrong");
    a_read_clears: assert property (rdr_rd && !rdr_complete && !tape_no_sel && !run_lost
        |=> !rdr_flag && io_data == $past(rdr_buf)) // [R10]
        else $error("read did not clear flag or move buffer");
    a_merge_mode: assert property (rdr_rd |=> io_data_or == !$past(xfer.code[ptrp_pkg::BIT_RDCLR])) // [R25]
        else $error("merge mode wrong");
    a_status_bits: assert property (io_status_read && !rdr_rd |=> io_data[16] == $past(rdr_flag)
        && io_data[15] == $past(pun_flag) && io_data[9] == $past(filt.no_tape)) // [R22]
        else $error("status word wrong");
    a_readin_binary: assert property (readin_active |-> bin_mode) // [R1]
        else $error("readin not in binary mode");
    a_readin_skip: assert property (rdr_complete && readin_active && next_last
        |=> readin_irq && readin_skip [*1] ##1 (readin_skip || $past(readin_take))) // [R4]
        else $error("final word skip missing");
    a_bin_three: assert property (rdr_complete && bin_mode |-> fifo_frame[ptrp_pkg::CH8]
        && frame_cnt == 2'h2) // [R12]
        else $error("binary word not three frames");
    a_no_tape_flag: assert property (tape_no_sel |=> rdr_flag) // [R26]
        else $error("no tape did not set flag");
    a_pun_low_stop: assert property (filt.pun_low |-> !pun_motor ##1 !pun_strobe) // [R14]
        else $error("punch ran on low tape");
    a_pun_binary: assert property (pun_go_ok && pun_bin |=> pun_frame == {2'h2, $past(io_ac[5:0])}) // [R17]
        else $error("binary frame wrong");
    a_pun_char: assert property (pun_go_ok && !pun_bin |=> pun_frame == $past(io_ac[7:0]) && pun_strobe) // [R16]
        else $error("character frame wrong");
    a_pun_clear: assert property (pun_clr && !pun_go_ok && !pun_finish |=> !pun_flag && pun_frame == 8'h00) // [R19]
        else $error("punch clear failed");
    a_reset_clear: assert property ($past(rst) |-> !rdr_flag && !pun_flag && !readin_active) // [R27]
        else $error("reset left state");

endmodule // ptrp_ctrl

// ### sim/ptrp_tape_model.sv
`timescale 1ns/1ps

// reader tape feeder and punch mechanism as seen from the pins
module ptrp_tape_model (
    input wire logic clk_sys,
    input wire logic rdr_advance,
    input wire logic [7:0] pun_frame,
    input wire logic pun_strobe,
    output logic [7:0] frame,
    output logic strobe,
    output logic pun_done
);
    logic [7:0] tape[$];
    logic [7:0] punched[$];

    task automatic load(input logic [7:0] f);
        tape.push_back(f);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // reader: one frame per strobe, only while advance is asked for
    initial
    begin
        frame = 8'h00;
        strobe = 1'b0;
        forever
        begin
            @(negedge clk_sys);
            if (rdr_advance === 1'b1 && tape.size() > 0)
            begin
                frame = tape.pop_front();
                strobe = 1'b1;
                // held long enough for the pin synchronisers
                repeat (6) @(negedge clk_sys);
                strobe = 1'b0;
                // between frames the sensors see the inverted frame: never the last value
                frame = ~frame;
                repeat (6) @(negedge clk_sys);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // punch: records each frame, reports done some time later
    initial
    begin
        pun_done = 1'b0;
        forever
        begin
            @(negedge clk_sys);
            if (pun_strobe === 1'b1)
            begin
                punched.push_back(pun_frame);
                repeat (10) @(negedge clk_sys);
                pun_done = 1'b1;
                repeat (6) @(negedge clk_sys);
                pun_done = 1'b0;
            end
        end
    end
endmodule // ptrp_tape_model

// ### sim/test_paper_tape_reader_punch_ctrl.sv
`timescale 1ns/1ps

module test_paper_tape_reader_punch_ctrl;
    localparam logic [5:0] rdr = ptrp_pkg::DEV_READER;
    localparam logic [5:0] pun = ptrp_pkg::DEV_PUNCH;
    logic clk_sys;
    logic rst;
    ptrp_pkg::ptrp_xfer_t xfer;
    ptrp_pkg::ptrp_pins_t pins;
    logic io_status_read;
    logic [17:0] io_ac;
    logic io_skip;
    logic [17:0] io_data;
    logic io_data_valid;
    logic io_data_or;
    logic reader_irq;
    logic punch_irq;
    logic readin_take;
    logic readin_irq;
    logic readin_skip;
    logic readin_active;
    logic rdr_advance;
    logic [7:0] pun_frame;
    logic pun_strobe;
    logic pun_motor;
    logic [7:0] frame;
    logic strobe;
    logic pun_done;
    logic no_tape;
    logic pun_low;
    logic pun_feed;
    logic readin_key;
    logic skip_seen;
    int n_mismatch;
    int checks_done;

    assign pins = {frame, strobe, no_tape, pun_done, pun_low, pun_feed, readin_key};

    ptrp_ctrl #(.FIFO_DEPTH(32)) dut (.clk_sys(clk_sys), .rst(rst), .xfer(xfer), .io_status_read(io_status_read),
        .io_ac(io_ac), .io_skip(io_skip), .io_data(io_data), .io_data_valid(io_data_valid),
        .io_data_or(io_data_or), .reader_irq(reader_irq), .punch_irq(punch_irq), .readin_take(readin_take),
        .readin_irq(readin_irq), .readin_skip(readin_skip), .readin_active(readin_active), .pins(pins),
        .rdr_advance(rdr_advance), .pun_frame(pun_frame), .pun_strobe(pun_strobe), .pun_motor(pun_motor));

    ptrp_tape_model tape_m (.clk_sys(clk_sys), .rdr_advance(rdr_advance), .pun_frame(pun_frame),
        .pun_strobe(pun_strobe), .frame(frame), .strobe(strobe), .pun_done(pun_done));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // skip answer is combinational, so it is taken inside the request cycle
    task automatic issue(input logic [5:0] dev, input logic [5:0] sub);
        @(negedge clk_sys);
        xfer = '{valid: 1'b1, code: {ptrp_pkg::XFER_OPCODE, dev, sub}};
        #1;
        skip_seen = io_skip;
        @(negedge clk_sys);
        xfer.valid = 1'b0;
    endtask

    task automatic wait_hi(input int sel, input int limit);
        for (int i = 0; i < limit; i++)
        begin
            if ((sel == 0 ? reader_irq : sel == 1 ? punch_irq : readin_irq) === 1'b1)
                break;
            @(negedge clk_sys);
        end
    endtask

    task automatic pulse_take;
        @(negedge clk_sys);
        readin_take = 1'b1;
        @(negedge clk_sys);
        readin_take = 1'b0;
    endtask

    task automatic complete_run;
        $display("mismatches %0d, comparisons %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_char;
        tape_m.load(8'hC5);
        issue(rdr, 6'h01);
        check("idle skip", 18'h00000, 18'(skip_seen));
        issue(rdr, 6'h04);
        check("rdr_advance", 18'h00001, 18'(rdr_advance));
        wait_hi(0, 200);
        check("reader_irq", 18'h00001, 18'(reader_irq));
        check("advance stop", 18'h00000, 18'(rdr_advance));
        issue(rdr, 6'h01);
        check("reader skip", 18'h00001, 18'(skip_seen));
        issue(rdr, 6'h0A);
        check("char data", 18'h000C5, io_data);
        check("valid or flag", 18'h00004, {15'h0000, io_data_valid, io_data_or, reader_irq});
    endtask

    task automatic t_binary;
        logic [7:0] f[4] = '{8'h81, 8'h3F, 8'hA2, 8'h95};
        tape_m.load(8'h5A);
        issue(rdr, 6'h04);
        wait_hi(0, 200);
        foreach (f[i]) tape_m.load(f[i]);
        issue(rdr, 6'h24);
        check("flag at select", 18'h00000, 18'(reader_irq));
        wait_hi(0, 400);
        check("binary flag", 18'h00001, 18'(reader_irq));
        issue(rdr, 6'h02);
        check("binary word", 18'h01895, io_data);
        check("or read", 18'h00006, {15'h0000, io_data_valid, io_data_or, reader_irq});
    endtask

    task automatic t_punch;
        io_ac = 18'h3FFA5;
        issue(pun, 6'h04);
        check("punch start", 18'h00006, {15'h0000, pun_strobe, pun_motor, punch_irq});
        check("punch buffer", 18'h000A5, 18'(pun_frame));
        issue(pun, 6'h01);
        check("busy skip", 18'h00000, 18'(skip_seen));
        wait_hi(1, 200);
        check("punch flag", 18'h00001, 18'(punch_irq));
        issue(pun, 6'h01);
        check("punch skip", 18'h00001, 18'(skip_seen));
        check("char punched", 18'h000A5, 18'(tape_m.punched[$]));
        io_ac = 18'h0007B;
        issue(pun, 6'h24);
        check("binary frame", 18'h000BB, 18'(pun_frame));
        wait_hi(1, 200);
        check("binary flag", 18'h00001, 18'(punch_irq));
    endtask

    task automatic t_status;
        no_tape = 1'b1;
        pun_low = 1'b1;
        repeat (8) @(negedge clk_sys);
        issue(rdr, 6'h04);
        wait_hi(0, 50);
        check("no tape flag", 18'h00001, 18'(reader_irq));
        @(negedge clk_sys);
        io_status_read = 1'b1;
        @(negedge clk_sys);
        io_status_read = 1'b0;
        check("status word", 18'h18300, io_data);
        check("status valid", 18'h00001, 18'(io_data_valid));
    endtask

    task automatic t_punch_stop;
        logic seen;
        issue(pun, 6'h02);
        check("punch clear", 18'h00000, {9'h000, punch_irq, pun_frame});
        seen = 1'b0;
        issue(pun, 6'h04);
        repeat (6)
        begin
            seen = seen | pun_strobe | pun_motor;
            @(negedge clk_sys);
        end
        check("low tape", 18'h00000, {16'h0000, seen, punch_irq});
        pun_low = 1'b0;
        no_tape = 1'b0;
        pun_feed = 1'b1;
        repeat (8) @(negedge clk_sys);
        check("feed motor", 18'h00001, 18'(pun_motor));
        pun_feed = 1'b0;
        repeat (8) @(negedge clk_sys);
        check("motor stop", 18'h00000, 18'(pun_motor));
    endtask

    task automatic t_readin;
        logic [7:0] f[6] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'hC6};
        readin_key = 1'b1;
        repeat (8) @(negedge clk_sys);
        readin_key = 1'b0;
        check("readin latch", 18'h00001, 18'(readin_active));
        foreach (f[i]) tape_m.load(f[i]);
        wait_hi(2, 400);
        check("first word", 18'h01083, io_data);
        check("not final", 18'h00000, 18'(readin_skip));
        pulse_take();
        check("taken", 18'h00000, {16'h0000, readin_irq, readin_skip});
        wait_hi(2, 400);
        check("last word", 18'h04146, io_data);
        check("final skip", 18'h00001, 18'(readin_skip));
        pulse_take();
        repeat (2) @(negedge clk_sys);
        check("readin done", 18'h00000, 18'(readin_active));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // whole run is a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        $display("unexpected run length: expected finish, seen hang");
        complete_run();
    end

    initial
    begin
        n_mismatch = 0;
        checks_done = 0;
        rst = 1'b1;
        xfer = '0;
        io_status_read = 1'b0;
        io_ac = 18'h00000;
        readin_take = 1'b0;
        no_tape = 1'b0;
        pun_low = 1'b0;
        pun_feed = 1'b0;
        readin_key = 1'b0;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        check("reset state", 18'h00000, {6'h00, reader_irq, punch_irq, readin_active, readin_irq, pun_frame});
        t_char();
        t_binary();
        t_punch();
        t_status();
        t_punch_stop();
        t_readin();
        complete_run();
    end
endmodule // test_paper_tape_reader_punch_ctrl
